/* File: rtl/adc_poll_pkg.sv */
// Package: register offsets, field layouts, codes and timing of the polled converter interface
package adc_poll_pkg;

  // Register offsets on the byte-wide I/O port (4-bit offset from base)
  localparam logic [3:0] OFF_RESULT_LOW    = 4'h4;
  localparam logic [3:0] OFF_RESULT_HIGH   = 4'h5;
  localparam logic [3:0] OFF_GAIN_SELECT   = 4'h9;
  localparam logic [3:0] OFF_CHANNEL_SEL   = 4'ha;
  localparam logic [3:0] OFF_CONV_TRIGGER  = 4'hc;

  // Field layout
  localparam int         BUSY_BIT          = 4;
  localparam logic [7:0] BUSY_MASK         = 8'h10;
  localparam logic [7:0] HIGH_NIBBLE_MASK  = 8'h0f;
  localparam int         CHAN_W            = 5;
  localparam int         GAIN_W            = 3;
  localparam int         RESULT_W          = 12;
  localparam int         LOW_BYTE_W        = 8;

  // Gain codes
  localparam logic [2:0] GAIN_X1           = 3'h0;
  localparam logic [2:0] GAIN_X2           = 3'h1;
  localparam logic [2:0] GAIN_X4           = 3'h2;
  localparam logic [2:0] GAIN_X8           = 3'h3;
  localparam logic [2:0] GAIN_X16          = 3'h4;

  // Result reset value and bipolar zero code
  localparam logic [11:0] RESULT_RESET     = 12'h000;
  localparam logic [11:0] BIPOLAR_ZERO     = 12'h800;
  localparam logic [11:0] RESULT_MAX       = 12'hfff;
  localparam logic [7:0]  READ_IDLE        = 8'h00;

  // Conversion time of the converter core and its cycle count at 20 MHz
  localparam int CLOCK_HZ                  = 20_000_000;
  localparam int CONV_TIME_NS              = 10_000;
  localparam int CONV_CYCLES               = (CONV_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [9:0] CONV_CYCLES_V     = 10'(CONV_CYCLES);

  // Host bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  // Analog front-end control
  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic [GAIN_W-1:0] gain;
  } afe_ctrl_t;

endpackage

/* File: rtl/adc_poll_regs.sv */
// Polled converter register interface: channel, gain, trigger, busy and result registers
//
// What this block does
// R1: Host writes offset 10 to pick the analog input routed to the converter.
// R2: Any write to offset 12 starts one conversion; data is ignored.
// R3: Bit 0x10 of offset 5 is high while converting, low when result valid.
// R4: Offset 4 holds low eight result bits; offset 5 bits 3:0 the high four.
// R5: Each result is a 12-bit unsigned value, 0 to 4095.
// R6: Direct binary coding; bipolar 800 hex is zero volts, code zero is minus full.
// R7: Gain is unity after reset until software writes another code.
// R8: Write-only gain register at offset 9, 3-bit code 0..4 gives 1..16.
// R9: Channel register uses five low bits as channel 0..31; top bits ignored.
// R10: Busy rises in the same cycle as the trigger write is taken.
`timescale 1ns/1ps
`default_nettype none

module adc_poll_regs
  import adc_poll_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_sys_rst,
  // Host I/O port
  input  wire io_req_t               i_io_req,
  output logic [7:0]                 o_io_rdata,
  // Converter core
  input  wire logic [RESULT_W-1:0]   i_adc_sample,
  output afe_ctrl_t                  o_afe_ctrl,
  output logic                       o_adc_start,
  output logic                       o_conversion_pending_flag
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} conv_state_t;

  function automatic logic hit(input io_req_t req, input logic [3:0] off);
    return req.addr == off;
  endfunction

  conv_state_t         state_r;
  logic [9:0]          count_r;
  logic [CHAN_W-1:0]   channel_number_bits_r;
  logic [GAIN_W-1:0]   gain_r;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] sample_s1_r;
  logic [RESULT_W-1:0] sample_s2_r;
  logic                trig_wr;

  assign trig_wr = i_io_req.wr && hit(i_io_req, OFF_CONV_TRIGGER);

  ////////////////////////////////////////////////////////////////////////////
  // R9: five-bit channel
  // R1: channel routing
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      channel_number_bits_r <= '0;
    end else if (i_io_req.wr && hit(i_io_req, OFF_CHANNEL_SEL)) begin
      channel_number_bits_r <= i_io_req.wdata[CHAN_W-1:0];
    end
  end

  // R7: unity gain default
  // R8: gain write-only
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gain_r <= GAIN_X1;
    end else if (i_io_req.wr && hit(i_io_req, OFF_GAIN_SELECT)
                 && i_io_req.wdata[GAIN_W-1:0] <= GAIN_X16) begin
      gain_r <= i_io_req.wdata[GAIN_W-1:0];
    end
  end

  assign o_afe_ctrl = '{channel: channel_number_bits_r, gain: gain_r};

  ////////////////////////////////////////////////////////////////////////////
  // Converter output arrives from another domain: two-stage synchroniser
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sample_s1_r <= RESULT_RESET;
      sample_s2_r <= RESULT_RESET;
    end else begin
      sample_s1_r <= i_adc_sample;
      sample_s2_r <= sample_s1_r;
    end
  end

  // R2: trigger starts one conversion
  // R10: busy in trigger cycle
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
      count_r <= '0;
    end else if (trig_wr) begin
      state_r <= ST_CONVERT;
      count_r <= CONV_CYCLES_V;
    end else begin
      unique case (state_r)
        ST_IDLE:    count_r <= '0;
        ST_CONVERT: begin
          count_r <= count_r - 10'h001;
          if (count_r == 10'h001) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // R5: 12-bit unsigned result
  // R6: direct binary, passed unchanged
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      result_r <= RESULT_RESET;
    end else if (state_r == ST_CONVERT && count_r == 10'h001 && !trig_wr) begin
      result_r <= sample_s2_r;
    end
  end

  // R3: busy flag
  assign o_conversion_pending_flag = (state_r == ST_CONVERT) || trig_wr;
  assign o_adc_start               = trig_wr;

  ////////////////////////////////////////////////////////////////////////////
  // R4: result byte split
  always_comb begin
    o_io_rdata = READ_IDLE;
    if (i_io_req.rd && hit(i_io_req, OFF_RESULT_LOW)) begin
      o_io_rdata = result_r[LOW_BYTE_W-1:0];
    end else if (i_io_req.rd && hit(i_io_req, OFF_RESULT_HIGH)) begin
      o_io_rdata           = 8'(result_r >> LOW_BYTE_W);
      o_io_rdata[BUSY_BIT] = (state_r == ST_CONVERT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Cycles since the last trigger, saturating at the conversion length
  logic [9:0] since_trig_r;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      since_trig_r <= CONV_CYCLES_V;
    end else if (trig_wr) begin
      since_trig_r <= '0;
    end else if (since_trig_r != CONV_CYCLES_V) begin
      since_trig_r <= since_trig_r + 10'h001;
    end
  end

  sequence s_trigger;
    trig_wr;
  endsequence

  sequence s_busy_run;
    o_conversion_pending_flag [*8];
  endsequence

  a_busy_on_trigger: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R10
    s_trigger |=> o_conversion_pending_flag && (count_r == CONV_CYCLES_V))
    else $error("busy not set after trigger");

  a_busy_holds: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R3
    s_trigger |-> s_busy_run)
    else $error("busy dropped early");

  a_busy_ends: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R3
    (since_trig_r == CONV_CYCLES_V && !trig_wr) |-> !o_conversion_pending_flag)
    else $error("busy still set after conversion time");

  a_busy_window: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R3
    (since_trig_r != CONV_CYCLES_V) |-> (state_r == ST_CONVERT))
    else $error("busy dropped before conversion time");

  a_result_capture: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R5
    ($past(state_r) == ST_CONVERT && state_r == ST_IDLE)
      |-> result_r == $past(sample_s2_r))
    else $error("result not taken at conversion end");

  a_read_idle: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R4
    !i_io_req.rd |-> o_io_rdata == READ_IDLE)
    else $error("read data not idle without a read");

  a_high_top_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R4
    (i_io_req.rd && hit(i_io_req, OFF_RESULT_HIGH))
      |-> (o_io_rdata & ~(BUSY_MASK | HIGH_NIBBLE_MASK)) == 8'h00)
    else $error("unused high bits set");

  a_start_pulse: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R2
    o_adc_start |-> ##1 (state_r == ST_CONVERT))
    else $error("trigger did not start conversion");

  a_low_byte: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R4
    (i_io_req.rd && hit(i_io_req, OFF_RESULT_LOW)) |-> o_io_rdata == result_r[LOW_BYTE_W-1:0])
    else $error("low result byte wrong");

  a_high_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R3
    (i_io_req.rd && hit(i_io_req, OFF_RESULT_HIGH))
      |-> ((o_io_rdata & BUSY_MASK) != 8'h00) == (state_r == ST_CONVERT))
    else $error("busy bit readback wrong");

  a_high_nibble: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R4
    (i_io_req.rd && hit(i_io_req, OFF_RESULT_HIGH))
      |-> (o_io_rdata & HIGH_NIBBLE_MASK) == 8'(result_r >> LOW_BYTE_W))
    else $error("high result nibble wrong");

  a_gain_legal: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R8
    o_afe_ctrl.gain <= GAIN_X16)
    else $error("gain code out of range");

  a_gain_reject: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R8
    (i_io_req.wr && hit(i_io_req, OFF_GAIN_SELECT)
      && i_io_req.wdata[GAIN_W-1:0] > GAIN_X16)
      |=> $stable(o_afe_ctrl.gain))
    else $error("illegal gain code taken");

  a_channel_write: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R9
    (i_io_req.wr && hit(i_io_req, OFF_CHANNEL_SEL))
      |=> o_afe_ctrl.channel == $past(i_io_req.wdata[CHAN_W-1:0]))
    else $error("channel not taken from low five bits");

  a_result_stable: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R5
    (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> $stable(result_r))
    else $error("result changed while idle");

endmodule // adc_poll_regs

`default_nettype wire

/* File: testbench/adc_core_model.sv */
// Converter core model: holds the analog level taken at each start pulse
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
  import adc_poll_pkg::*;
(
  // Clock and start
  input  wire logic                i_clock,
  input  wire logic                i_start,
  // Analog level and sample
  input  wire logic [RESULT_W-1:0] i_level,
  output logic      [RESULT_W-1:0] o_sample
);
  // Sample stays put for the whole conversion
  always_ff @(posedge i_clock) begin
    if (i_start) begin
      o_sample <= i_level;
    end
  end
endmodule // adc_core_model
`default_nettype wire

/* File: testbench/adc_poll_regs_tb_top.sv */
// Testbench: host port reads and writes against the converter registers
`timescale 1ns/1ps
`default_nettype none
module adc_poll_regs_tb_top
  import adc_poll_pkg::*;
;
  logic          i_clock = 1'b0;
  logic          i_sys_rst = 1'b1;
  io_req_t       req = '0;
  logic [7:0]    rdata;
  logic [11:0]   level = 12'h000;
  logic [11:0]   sample;
  afe_ctrl_t     afe;
  logic          start;
  logic          pend;
  int            checked = 0;
  int            n_mismatch = 0;
  logic [7:0]    d;

  always #25 i_clock = ~i_clock;

  adc_poll_regs adc_poll_regs_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_io_req(req), .o_io_rdata(rdata),
    .i_adc_sample(sample), .o_afe_ctrl(afe), .o_adc_start(start),
    .o_conversion_pending_flag(pend));
  adc_core_model adc_core_model_inst (
    .i_clock(i_clock), .i_start(start), .i_level(level), .o_sample(sample));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic io_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_clock);
    req <= '0;
    #1;
  endtask

  task automatic io_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clock);
    v = rdata;
    req <= '0;
  endtask

  task automatic convert(input logic [11:0] v);
    int n;
    logic [7:0] lo;
    logic [7:0] hi;
    level = v;
    @(posedge i_clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: OFF_CONV_TRIGGER, wdata: 8'h5a};
    #1;
    check(12'(start), 12'h001, "start");
    check(12'(pend), 12'h001, "pending");
    @(posedge i_clock);
    req <= '0;
    n = 0;
    hi = BUSY_MASK;
    while ((hi & BUSY_MASK) !== 8'h00 && n < 400) begin
      io_rd(OFF_RESULT_HIGH, hi);
      n++;
    end
    if ((hi & BUSY_MASK) !== 8'h00) begin
      n_mismatch++;
      stop_test();
    end
    check(12'(n > 1), 12'h001, "busy seen");
    io_rd(OFF_RESULT_LOW, lo);
    check({hi[3:0], lo}, v, "result");
  endtask

  initial begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    check(12'(afe.gain), 12'(GAIN_X1), "gain reset");
    check(12'(pend), 12'h000, "idle busy");
    $display("reset test done");
    io_wr(OFF_CHANNEL_SEL, 8'hff);
    check(12'(afe.channel), 12'h01f, "channel");
    io_wr(OFF_CHANNEL_SEL, 8'he2);
    check(12'(afe.channel), 12'h002, "channel");
    $display("channel test done");
    for (int i = 0; i < 5; i++) begin
      io_wr(OFF_GAIN_SELECT, 8'(i));
      check(12'(afe.gain), 12'(i), "gain");
    end
    io_wr(OFF_GAIN_SELECT, 8'h07);
    check(12'(afe.gain), 12'(GAIN_X16), "gain kept");
    io_rd(OFF_GAIN_SELECT, d);
    check(12'(d), 12'(READ_IDLE), "gain unreadable");
    $display("gain test done");
    io_wr(OFF_CONV_TRIGGER, 8'h00);
    check(12'(pend), 12'h001, "busy before reset");
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    #1;
    check(12'(pend), 12'h000, "busy in reset");
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    check(12'(afe.gain), 12'(GAIN_X1), "gain after reset");
    check(12'(afe.channel), 12'h000, "channel after reset");
    $display("mid-run reset test done");
    convert(12'h000);
    convert(BIPOLAR_ZERO);
    convert(RESULT_MAX);
    $display("conversion test done");
    stop_test();
  end
endmodule // adc_poll_regs_tb_top
`default_nettype wire
